// *** core/frm_ctrl.sv ***
// Purpose: Reset, mode, replay and port control of a dual-port FIFO
// Assumes: ref_clk far faster than the port clocks and strobes
// Notes:
// Notes on behaviour
// - Full reinit zeroes both pointers; almost-empty low, almost-full and half-full high.
// - Fall-through select low at full reinit: standard mode, empty low, full high.
// - Fall-through select high at full reinit: output-valid high, input-ready low.
// - Width, order, latency, timing, parity settings latched while full reinit held.
// - Full reinit clears output register asynchronously; required after power up.
// - Pointer reset zeroes pointers, sets flags as full reinit does, keeps mode, shows that mode empty.
// - Pointer reset is asynchronous, keeps offsets and load method, clears output.
// - Async write port: write clock is a strobe; push enable tied low.
// - Async write port: full flag follows writes and reads at once; no fall-through.
// - Async read port: read clock is a strobe reading via output register.
// - Async read port: standard mode only, empty flag follows reads and writes.
// - Output drive enable high floats read data at once, clock independent.
// - Replay low at a read clock edge starts retransmit setup.
// - Standard setup drives empty low while read pointer returns to start.
// - Fall-through setup: output-valid high, then first word shown without pop.
// - Latency select low at reinit means zero latency, high means normal.
// - Zero latency loads first replayed word on the replay edge itself.
// - Fall-through: first word into empty FIFO appears after three read edges.
// - After reinit the fall-through pin is serial offset input if chosen.
// - Writes start on write clock rising edge; clocks may be independent.
// - Stopped write clock freezes almost-full, and full except on an async write port; it only drives half-full low.
// - Push enable low stores a word each write edge unless full.
// - Pop enable low and not empty loads next word each read edge.
`timescale 1ns/100ps
`include "frm_map.svh"

////////////////////////////////////////////////////////////////////////////////
module frm_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } frm_syn_t;
  frm_syn_t r, n;
  always_comb begin
    n    = r;
    n.s1 = d;
    n.s2 = r.s1;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) r <= '0;
    else r <= n;
  end
  assign q = r.s2;
endmodule : frm_sync

////////////////////////////////////////////////////////////////////////////////
module frm_buf #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire logic                 clr,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [W-1:0]         in_data,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic      [W-1:0]         out_data,
  output logic      [$clog2(D):0]   level
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } frm_bst_t;
  frm_bst_t     r, n;
  logic [W-1:0] mem [D];
  assign level     = r.wp - r.rp;
  assign in_ready  = level != (AW+1)'(D);
  assign out_valid = level != '0;
  assign out_data  = mem[r.rp[AW-1:0]];
  always_comb begin
    n = r;
    if (clr) n = '0;
    else begin
      if (in_valid && in_ready) n.wp = r.wp + 1'b1;
      if (out_valid && out_ready) n.rp = r.rp + 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) r <= '0;
    else r <= n;
  end
  always_ff @(posedge ref_clk) begin
    if (in_valid && in_ready && !clr) mem[r.wp[AW-1:0]] <= in_data;
  end
endmodule : frm_buf

////////////////////////////////////////////////////////////////////////////////
module frm_ctrl import frm_pkg::*; #(
  parameter int DW        = `FRM_DATA_W,
  parameter int DEPTH     = `FRM_RAM_DEPTH,
  parameter int BUF_DEPTH = `FRM_BUF_DEPTH,
  parameter int AE_OFF    = `FRM_AE_OFF,
  parameter int AF_OFF    = `FRM_AF_OFF
) (
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  input  wire logic          full_reinit_n,
  input  wire logic          pointer_reset_n,
  input  wire logic          wr_clk_pin,
  input  wire logic          rd_clk_pin,
  input  wire logic          push_en_n,
  input  wire logic          pop_en_n,
  input  wire logic          replay_n,
  input  wire logic          out_drive_en_n,
  input  wire logic          fallthrough_select_serial_in,
  input  wire logic          write_port_async_sel,
  input  wire logic          read_port_async_sel,
  input  wire logic          replay_latency_sel,
  input  wire logic          out_width_sel,
  input  wire logic          in_width_sel,
  input  wire logic          byte_order_sel,
  input  wire logic          flag_timing_sel,
  input  wire logic          parity_insert_sel,
  input  wire logic          serial_load_sel,
  input  wire logic [DW-1:0] write_data,
  output logic      [DW-1:0] read_data,
  output logic               read_data_oe_n,
  output logic               empty_flag_n,
  output logic               full_flag_n,
  output logic               almost_empty_flag,
  output logic               almost_full_flag,
  output logic               half_full_flag,
  output logic               serial_in_bit,
  output logic               serial_in_en,
  output frm_cfg_t           cfg_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int BW = $clog2(BUF_DEPTH);
  localparam int SW = `FRM_CTL_W + `FRM_CFG_W + DW;
  localparam logic [AW+1:0] FULL_CNT = (AW+2)'(DEPTH);
  localparam logic [AW+1:0] HALF_CNT = (AW+2)'(DEPTH / 2);
  localparam logic [AW+1:0] AF_CNT   = (AW+2)'(DEPTH - AF_OFF);
  localparam logic [AW:0]   AE_CNT   = (AW+1)'(AE_OFF);

  typedef struct packed {
    logic [AW:0]   wptr;
    logic [AW:0]   rptr;
    logic [DW-1:0] q;
    logic          valid;
    logic          empty;
    logic          full;
    logic          ae;
    logic          af;
    logic          hf;
    logic          rt_setup;
    logic          wclk_d;
    logic          rclk_d;
    logic [1:0]    fall_cnt;
    frm_cfg_t      cfg;
  } frm_st_t;
  localparam frm_st_t ST_RST = '{wptr: '0, rptr: '0, q: '0, valid: 1'b0, empty: 1'b1,
    full: 1'b0, ae: 1'b0, af: 1'b1, hf: 1'b1, rt_setup: 1'b0, wclk_d: 1'b0,
    rclk_d: 1'b0, fall_cnt: '0, cfg: '0};

  frm_st_t       r, n;
  logic [DW-1:0] mem [DEPTH];
  logic [SW-1:0] s;
  logic          wclk_s, rclk_s, push_n_s, pop_n_s, rp_s, fr_s, pr_s, fall_through_mode_s;
  logic [8:0]    cfgp_s;
  logic [DW-1:0] wd_s;
  frm_cfg_t      cfg_s;
  logic          wr_edge, rd_edge, wr_req, drain_go, live, buf_ir, buf_ov, rst_raw, mode_now;
  logic [DW-1:0] buf_q, mem_first;
  logic [BW:0]   buf_lvl;
  logic [AW:0]   cnt;
  logic [AW+1:0] occ, occ_after;

  ////////////////////////////////////////////////////////////////////////////////
  // Every pin passes two flops before use, except output drive enable; reset pins and fall-through select also act raw
  frm_sync #(.W(SW)) u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .d       ({write_data, parity_insert_sel, flag_timing_sel, byte_order_sel,
                in_width_sel, out_width_sel, replay_latency_sel, read_port_async_sel,
                write_port_async_sel, serial_load_sel, fallthrough_select_serial_in,
                pointer_reset_n, full_reinit_n, replay_n, pop_en_n, push_en_n,
                rd_clk_pin, wr_clk_pin}),
    .q       (s)
  );
  assign {wd_s, cfgp_s, fall_through_mode_s, pr_s, fr_s, rp_s, pop_n_s, push_n_s, rclk_s, wclk_s} = s;
  assign cfg_s = '{fall_through_mode: fall_through_mode_s, wr_async: ~cfgp_s[1], rd_async: ~cfgp_s[2],
                   zero_lat: ~cfgp_s[3], out_w: cfgp_s[4], in_w: cfgp_s[5],
                   byte_order: cfgp_s[6], flag_timing: cfgp_s[7], parity: cfgp_s[8],
                   serial_load: cfgp_s[0]};

  assign live      = fr_s && pr_s;
  assign wr_edge   = wclk_s && !r.wclk_d;
  assign rd_edge   = rclk_s && !r.rclk_d;
  assign cnt       = r.wptr - r.rptr;
  assign occ       = {1'b0, cnt} + (AW+2)'(buf_lvl);
  assign wr_req    = wr_edge && (r.cfg.wr_async || !push_n_s) && occ < FULL_CNT
                     && buf_ir && live;
  assign occ_after = occ + (AW+2)'(wr_req);
  assign drain_go  = buf_ov && cnt < (AW+1)'(DEPTH) && !r.rt_setup && live;
  assign mem_first = mem[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Staging buffer between write pins and RAM; stalls during replay setup
  frm_buf #(.W(DW), .D(BUF_DEPTH)) u_buf (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .clr       (!live),
    .in_valid  (wr_req),
    .in_ready  (buf_ir),
    .in_data   (wd_s),
    .out_valid (buf_ov),
    .out_ready (drain_go),
    .out_data  (buf_q),
    .level     (buf_lvl)
  );

  always_ff @(posedge ref_clk) begin
    if (drain_go) mem[r.wptr[AW-1:0]] <= buf_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n        = r;
    n.wclk_d = wclk_s;
    n.rclk_d = rclk_s;
    if (!live) begin
      n          = ST_RST;
      n.wclk_d   = wclk_s;
      n.rclk_d   = rclk_s;
      n.cfg      = fr_s ? r.cfg : cfg_s;
    end else begin
      if (drain_go) n.wptr = r.wptr + 1'b1;
      if (rd_edge) begin
        if (!rp_s) begin
          n.rptr  = '0;
          n.valid = 1'b0;
          if (r.cfg.zero_lat) begin
            if (r.wptr != '0) begin
              n.q     = mem_first;
              n.rptr  = (AW+1)'(1);
              n.valid = 1'b1;
            end
          end else begin
            n.rt_setup = 1'b1;
          end
        end else if (r.rt_setup) begin
          n.rt_setup = 1'b0;
          if (r.cfg.fall_through_mode && r.wptr != '0) begin
            n.q     = mem_first;
            n.rptr  = (AW+1)'(1);
            n.valid = 1'b1;
          end
        end else if (r.cfg.fall_through_mode) begin
          if (r.valid && !pop_n_s) begin
            if (cnt != '0) begin
              n.q    = mem[r.rptr[AW-1:0]];
              n.rptr = r.rptr + 1'b1;
            end else begin
              n.valid = 1'b0;
            end
          end else if (!r.valid && cnt != '0) begin
            if (r.fall_cnt == `FRM_FALL_LAST) begin
              n.q        = mem[r.rptr[AW-1:0]];
              n.rptr     = r.rptr + 1'b1;
              n.valid    = 1'b1;
              n.fall_cnt = '0;
            end else begin
              n.fall_cnt = r.fall_cnt + 1'b1;
            end
          end
        end else if ((r.cfg.rd_async || !pop_n_s) && cnt != '0) begin
          n.q    = mem[r.rptr[AW-1:0]];
          n.rptr = r.rptr + 1'b1;
        end
        n.empty = n.rt_setup || r.wptr == n.rptr;
        n.ae    = (r.wptr - n.rptr) > AE_CNT;
        if ({1'b0, r.wptr - n.rptr} <= HALF_CNT) n.hf = 1'b1;
      end
      if (wr_edge) begin
        n.full = occ_after >= FULL_CNT;
        n.af   = occ_after < AF_CNT;
        if (occ_after > HALF_CNT) n.hf = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) r <= ST_RST;
    else r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Raw reset pins override the flags and read data without waiting for the clock
  assign rst_raw  = !full_reinit_n || !pointer_reset_n;
  assign mode_now = !full_reinit_n ? fallthrough_select_serial_in : r.cfg.fall_through_mode;

  always_comb begin
    if (rst_raw) begin
      empty_flag_n      = mode_now;
      full_flag_n       = ~mode_now;
      almost_empty_flag = 1'b0;
      almost_full_flag  = 1'b1;
      half_full_flag    = 1'b1;
      read_data         = '0;
    end else begin
      if (r.cfg.fall_through_mode) empty_flag_n = ~r.valid;
      else if (r.cfg.rd_async) empty_flag_n = ~(cnt == '0 || r.rt_setup);
      else empty_flag_n = ~r.empty;
      if (r.cfg.fall_through_mode) full_flag_n = r.full;
      else if (r.cfg.wr_async) full_flag_n = occ < FULL_CNT;
      else full_flag_n = ~r.full;
      almost_empty_flag = r.ae;
      almost_full_flag  = r.af;
      half_full_flag    = r.hf;
      read_data         = r.q;
    end
  end

  assign read_data_oe_n = out_drive_en_n;
  assign serial_in_bit  = fall_through_mode_s;
  assign serial_in_en   = fr_s && r.cfg.serial_load;
  assign cfg_out        = r.cfg;

  ////////////////////////////////////////////////////////////////////////////////
  reinit_flags_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !full_reinit_n |-> !almost_empty_flag && almost_full_flag && half_full_flag)
    else $error("reinit flags wrong");
  reinit_std_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !full_reinit_n && !fallthrough_select_serial_in |-> !empty_flag_n && full_flag_n)
    else $error("standard reinit flags wrong");
  reinit_fall_through_mode_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !full_reinit_n && fallthrough_select_serial_in |-> empty_flag_n && !full_flag_n)
    else $error("fall-through reinit flags wrong");
  cfg_latch_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    resetn && !fr_s |=> r.cfg == $past(cfg_s))
    else $error("config not latched");
  out_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    rst_raw |-> read_data == '0)
    else $error("output not cleared");
  ptr_reset_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    fr_s && !pr_s |=> r.wptr == '0 && r.rptr == '0 && r.cfg == $past(r.cfg))
    else $error("pointer reset wrong");
  oe_follow_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    read_data_oe_n == out_drive_en_n)
    else $error("output enable not passed");
  zero_lat_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    live && rd_edge && !rp_s && r.cfg.zero_lat && r.wptr != '0
    |=> r.q == $past(mem_first) && r.rptr == 1 && !r.rt_setup)
    else $error("zero latency replay late");
  setup_empty_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    live && rd_edge && !rp_s && !r.cfg.zero_lat && !r.cfg.fall_through_mode
    |=> r.rt_setup && r.rptr == '0 && !empty_flag_n)
    else $error("setup does not show empty");
  full_ignore_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    live && occ >= FULL_CNT && !rd_edge |=> occ <= $past(occ))
    else $error("write taken while full");
  pop_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    live && rd_edge && rp_s && !r.rt_setup && !r.cfg.fall_through_mode && !pop_n_s && cnt != '0
    |=> r.rptr == $past(r.rptr) + 1'b1)
    else $error("pop did not advance");
  fall_three_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    r.cfg.fall_through_mode && !r.valid && n.valid && rp_s && !r.rt_setup
    |-> r.fall_cnt == `FRM_FALL_LAST)
    else $error("fall-through not on third edge");
  wclk_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    live && !wr_edge |=> r.full == $past(r.full) && r.af == $past(r.af))
    else $error("write flags moved without edge");

  replay_c: cover property (@(posedge ref_clk) live && rd_edge && !rp_s);
  fall_c:   cover property (@(posedge ref_clk) r.cfg.fall_through_mode && !r.valid && n.valid);
  fill_c:   cover property (@(posedge ref_clk) occ >= FULL_CNT);
  pop_c:    cover property (@(posedge ref_clk) !r.cfg.fall_through_mode && n.rptr != r.rptr);
endmodule : frm_ctrl

// *** core/frm_map.svh ***
// Purpose: Named constants of the FIFO reset, mode and replay control
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef FRM_MAP_SVH
`define FRM_MAP_SVH
`define FRM_DATA_W    18
`define FRM_RAM_DEPTH 512
`define FRM_BUF_DEPTH 32
`define FRM_AE_OFF    7
`define FRM_AF_OFF    7
`define FRM_FALL_LAST 2'd2
`define FRM_CTL_W     8
`define FRM_CFG_W     9
`endif

// *** core/frm_pkg.sv ***
// Purpose: Types shared by the FIFO reset, mode and replay control
// Assumes: Nothing
// Notes:   Configuration is caught while full reinit is held low
package frm_pkg;
  typedef struct packed {
    logic fall_through_mode;
    logic wr_async;
    logic rd_async;
    logic zero_lat;
    logic out_w;
    logic in_w;
    logic byte_order;
    logic flag_timing;
    logic parity;
    logic serial_load;
  } frm_cfg_t;
endpackage : frm_pkg

// *** tb/frm_peer.sv ***
// Purpose: Writer and reader logic at the FIFO data ports
// Assumes: Each strobe phase lasts at least 4 ref_clk cycles
// Notes:   A released data bus shows the inverse of the last word
`timescale 1ns/100ps
module frm_peer #(
  parameter int DW = 18
) (
  input  wire logic          ref_clk,
  output logic               wr_clk_pin,
  output logic               rd_clk_pin,
  output logic               push_en_n,
  output logic               pop_en_n,
  output logic               replay_n,
  output logic [DW-1:0]      write_data
);
  logic idle_push_n = 1'b1;
  logic idle_pop_n  = 1'b1;

  initial begin
    wr_clk_pin = 1'b0;
    rd_clk_pin = 1'b0;
    push_en_n  = 1'b1;
    pop_en_n   = 1'b1;
    replay_n   = 1'b1;
    write_data = '0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // One write edge; gap stretches the low phase for a slow writer
  task automatic put(input logic [DW-1:0] d, input logic en_n, input int gap);
    push_en_n  <= en_n;
    write_data <= d;
    tick(4 + gap);
    wr_clk_pin <= 1'b1;
    tick(4);
    wr_clk_pin <= 1'b0;
    push_en_n  <= idle_push_n;
    write_data <= ~d;
    tick(4);
  endtask : put

  // One read edge; replay held only around that edge, then released high
  task automatic pull(input logic p_n, input logic r_n, input int gap);
    pop_en_n <= p_n;
    replay_n <= r_n;
    tick(4 + gap);
    rd_clk_pin <= 1'b1;
    tick(4);
    rd_clk_pin <= 1'b0;
    pop_en_n   <= idle_pop_n;
    replay_n   <= 1'b1;
    tick(4);
  endtask : pull
endmodule : frm_peer

// *** tb/frm_ctrl_tb_top.sv ***
// Purpose: Self-checking bench of the FIFO reset, mode and replay control
// Assumes: Port strobes come from frm_peer
// Notes:   Small RAM and staging depths keep the run short
`timescale 1ns/100ps
module frm_ctrl_tb_top import frm_pkg::*;;
  localparam int DW  = 18;
  localparam int DEP = 16;
  logic ref_clk = 1'b0, resetn = 1'b0, full_reinit_n = 1'b0, pointer_reset_n = 1'b1;
  logic out_drive_en_n = 1'b0, fallthrough_select_serial_in = 1'b0;
  logic write_port_async_sel = 1'b1, read_port_async_sel = 1'b1, replay_latency_sel = 1'b1;
  logic out_width_sel = 1'b0, in_width_sel = 1'b0, byte_order_sel = 1'b0;
  logic flag_timing_sel = 1'b0, parity_insert_sel = 1'b0, serial_load_sel = 1'b0;
  logic wr_clk_pin, rd_clk_pin, push_en_n, pop_en_n, replay_n;
  logic [DW-1:0] write_data, read_data;
  logic read_data_oe_n, empty_flag_n, full_flag_n, almost_empty_flag, almost_full_flag;
  logic half_full_flag, serial_in_bit, serial_in_en;
  frm_cfg_t cfg_out;
  int errors = 0;
  int checked = 0;

  frm_ctrl #(.DEPTH(DEP), .BUF_DEPTH(4)) i_dut (
    .ref_clk, .resetn, .full_reinit_n, .pointer_reset_n, .wr_clk_pin, .rd_clk_pin,
    .push_en_n, .pop_en_n, .replay_n, .out_drive_en_n, .fallthrough_select_serial_in,
    .write_port_async_sel, .read_port_async_sel, .replay_latency_sel, .out_width_sel,
    .in_width_sel, .byte_order_sel, .flag_timing_sel, .parity_insert_sel,
    .serial_load_sel, .write_data, .read_data, .read_data_oe_n, .empty_flag_n,
    .full_flag_n, .almost_empty_flag, .almost_full_flag, .half_full_flag,
    .serial_in_bit, .serial_in_en, .cfg_out);

  frm_peer #(.DW(DW)) i_peer (
    .ref_clk, .wr_clk_pin, .rd_clk_pin, .push_en_n, .pop_en_n, .replay_n, .write_data);

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [DW-1:0] wd(input int i);
    return 18'h15a00 + DW'(i);
  endfunction : wd

  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_b(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_b

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_v

  task automatic rd_chk(input logic p_n, input logic r_n, input int i);
    i_peer.pull(p_n, r_n, 0);
    chk_v(32'(read_data), 32'(wd(i)));
  endtask : rd_chk

  // Config pins stay put for the whole reinit
  task automatic reinit(input frm_cfg_t c);
    full_reinit_n                <= 1'b0;
    fallthrough_select_serial_in <= c.fall_through_mode;
    write_port_async_sel         <= ~c.wr_async;
    read_port_async_sel          <= ~c.rd_async;
    replay_latency_sel           <= ~c.zero_lat;
    out_width_sel                <= c.out_w;
    in_width_sel                 <= c.in_w;
    byte_order_sel               <= c.byte_order;
    flag_timing_sel              <= c.flag_timing;
    parity_insert_sel            <= c.parity;
    serial_load_sel              <= c.serial_load;
    repeat (6) @(posedge ref_clk);
    chk_v(32'(read_data), 32'h0);
    chk_b(almost_empty_flag, 1'b0);
    chk_b(almost_full_flag, 1'b1);
    chk_b(half_full_flag, 1'b1);
    chk_b(empty_flag_n, c.fall_through_mode);
    chk_b(full_flag_n, ~c.fall_through_mode);
    chk_b(serial_in_en, 1'b0);
    full_reinit_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk_v(32'(cfg_out), 32'(c));
    chk_b(serial_in_en, c.serial_load);
  endtask : reinit

  ////////////////////////////////////////////////////////////////////////////////
  task automatic sc_std;
    reinit(frm_cfg_t'(10'h02a));
    for (int i = 0; i < 3; i++) begin
      i_peer.put(wd(i), 1'b0, i);
    end
    i_peer.put(wd(7), 1'b1, 0);
    i_peer.pull(1'b1, 1'b1, 0);
    chk_b(empty_flag_n, 1'b1);
    chk_v(32'(read_data), 32'h0);
    rd_chk(1'b0, 1'b1, 0);
    rd_chk(1'b0, 1'b1, 1);
    i_peer.pull(1'b1, 1'b0, 0);
    chk_b(empty_flag_n, 1'b0);
    i_peer.pull(1'b1, 1'b1, 0);
    chk_b(empty_flag_n, 1'b1);
    for (int i = 0; i < 3; i++) begin
      rd_chk(1'b0, 1'b1, i);
    end
    chk_b(empty_flag_n, 1'b0);
    rd_chk(1'b0, 1'b1, 2);
  endtask : sc_std

  task automatic sc_prs;
    i_peer.put(wd(4), 1'b0, 0);
    i_peer.put(wd(5), 1'b0, 0);
    pointer_reset_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk_b(empty_flag_n, 1'b0);
    chk_b(full_flag_n, 1'b1);
    chk_b(almost_empty_flag, 1'b0);
    chk_b(half_full_flag, 1'b1);
    chk_v(32'(read_data), 32'h0);
    pointer_reset_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk_v(32'(cfg_out), 32'h02a);
    i_peer.put(wd(6), 1'b0, 0);
    rd_chk(1'b0, 1'b1, 6);
  endtask : sc_prs

  task automatic sc_full;
    reinit(frm_cfg_t'(10'h000));
    for (int i = 0; i <= DEP; i++) begin
      i_peer.put(wd(i), 1'b0, i % 3);
    end
    chk_b(full_flag_n, 1'b0);
    chk_b(almost_full_flag, 1'b0);
    chk_b(half_full_flag, 1'b0);
    rd_chk(1'b0, 1'b1, 0);
    chk_b(full_flag_n, 1'b0);
    chk_b(almost_empty_flag, 1'b1);
    for (int i = 1; i < DEP; i++) begin
      rd_chk(1'b0, 1'b1, i);
    end
    chk_b(empty_flag_n, 1'b0);
    chk_b(half_full_flag, 1'b1);
  endtask : sc_full

  task automatic sc_fall_through_mode;
    reinit(frm_cfg_t'(10'h214));
    i_peer.put(wd(8), 1'b0, 0);
    chk_b(full_flag_n, 1'b0);
    i_peer.pull(1'b1, 1'b1, 0);
    i_peer.pull(1'b1, 1'b1, 1);
    chk_b(empty_flag_n, 1'b1);
    rd_chk(1'b1, 1'b1, 8);
    chk_b(empty_flag_n, 1'b0);
    i_peer.put(wd(9), 1'b0, 0);
    rd_chk(1'b0, 1'b1, 9);
    i_peer.pull(1'b0, 1'b1, 0);
    chk_b(empty_flag_n, 1'b1);
    i_peer.pull(1'b1, 1'b0, 0);
    chk_b(empty_flag_n, 1'b1);
    rd_chk(1'b1, 1'b1, 8);
    chk_b(empty_flag_n, 1'b0);
    rd_chk(1'b0, 1'b1, 9);
  endtask : sc_fall_through_mode

  task automatic sc_zero;
    reinit(frm_cfg_t'(10'h048));
    for (int i = 0; i < 2; i++) begin
      i_peer.put(wd(i), 1'b0, 0);
      rd_chk(1'b0, 1'b1, i);
    end
    rd_chk(1'b0, 1'b0, 0);
    rd_chk(1'b0, 1'b1, 1);
  endtask : sc_zero

  // Both ports as strobes, standard mode only, enables tied low
  task automatic sc_async;
    i_peer.idle_push_n = 1'b0;
    i_peer.idle_pop_n = 1'b0;
    i_peer.push_en_n <= 1'b0;
    i_peer.pop_en_n <= 1'b0;
    reinit(frm_cfg_t'(10'h181));
    i_peer.put(wd(3), 1'b0, 0);
    chk_b(empty_flag_n, 1'b1);
    chk_b(full_flag_n, 1'b1);
    i_peer.put(wd(4), 1'b0, 2);
    rd_chk(1'b0, 1'b1, 3);
    rd_chk(1'b0, 1'b1, 4);
    chk_b(empty_flag_n, 1'b0);
    for (int b = 1; b >= 0; b--) begin
      fallthrough_select_serial_in <= 1'(b);
      repeat (4) @(posedge ref_clk);
      chk_b(serial_in_bit, 1'(b));
    end
    out_drive_en_n <= 1'b1;
    #1;
    chk_b(read_data_oe_n, 1'b1);
    @(posedge ref_clk);
    out_drive_en_n <= 1'b0;
    #1;
    chk_b(read_data_oe_n, 1'b0);
    @(posedge ref_clk);
  endtask : sc_async

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sc_std;
    sc_prs;
    sc_full;
    sc_fall_through_mode;
    sc_zero;
    sc_async;
    wrap_up;
  end

  initial begin
    repeat (50000) @(posedge ref_clk);
    errors++;
    wrap_up;
  end
endmodule : frm_ctrl_tb_top
